// File: reset_cause_pkg.sv
// Purpose: Shared constants for the reset-cause flag block.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   The three cause flags and the interrupt bits share one layout.
package reset_cause_pkg;

    localparam int          REG_W         = 8;

    // Byte addresses of the registers.
    localparam logic [11:0] CAUSE_OFFSET  = 12'h000;
    localparam logic [11:0] IRQ_OFFSET    = 12'h004;
    localparam logic [11:0] MASK_OFFSET   = 12'h008;

    // Bit positions of the cause flags.
    localparam int          PIN_BIT       = 0;
    localparam int          WD_BIT        = 1;
    localparam int          WAKE_BIT      = 2;

    // Bits that exist; all others read as zero.
    localparam logic [7:0]  USED_BITS     = 8'h07;

    // Reset values.
    localparam logic [7:0]  CAUSE_RESET   = 8'h00;
    localparam logic [7:0]  IRQ_RESET     = 8'h00;
    localparam logic [7:0]  MASK_RESET    = 8'h00;

    // APB answer phase states.
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WAIT = 2'b01,
        BUS_DONE = 2'b11
    } bus_state_e;

endpackage

// File: reset_source_flags.sv
// Purpose: Records why the device last restarted, readable over APB.
// Assumes: Event inputs are one-cycle pulses synchronous to pclk.
// Notes:   presetn stands for power-on reset and clears every flag.
//
// What this block does
// - A recovery from stop state sets the wake flag.
// - Wake and watchdog flags both set means the watchdog caused the wake.
// - Power-on reset, or watchdog time-out outside stop, clears wake flag.
// - Reading the status register clears the wake flag.
// - A watchdog time-out sets the watchdog flag.
// - Power-on reset clears the watchdog flag.
// - A wake from stop by an input pin change clears watchdog flag.
// - A reset from the external reset pin sets the external flag.
// - Power-on reset or pin-change wake from stop clears external flag.
// - Reading the status register also clears watchdog and external flags.
`timescale 1ns/10ps
module reset_source_flags #(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              stop_recovery,
    input  wire logic              wake_from_pin,
    input  wire logic              in_stop_mode,
    input  wire logic              watchdog_timeout,
    input  wire logic              pin_reset_seen,
    output logic                   irq,
    output logic                   wake_flag,
    output logic                   watchdog_timeout_flag,
    output logic                   external_pin_reset_flag
);

    reset_cause_pkg::bus_state_e state;
    reset_cause_pkg::bus_state_e next_state;

    logic [7:0]  cause_q;
    logic [7:0]  irq_q;
    logic [7:0]  mask;
    logic [7:0]  cause_set;
    logic [7:0]  cause_clr;
    logic [7:0]  irq_clr;
    logic [31:0] rd_data;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        next_irq;

    wire [11:0] addr12   = 12'(paddr);
    wire        hit_cause = addr12 == reset_cause_pkg::CAUSE_OFFSET;
    wire        hit_irq   = addr12 == reset_cause_pkg::IRQ_OFFSET;
    wire        hit_mask  = addr12 == reset_cause_pkg::MASK_OFFSET;
    wire        hit_any   = hit_cause | hit_irq | hit_mask;
    wire        access    = psel & penable;
    wire        capture   = access & (state == reset_cause_pkg::BUS_IDLE);
    wire        done      = access & pready;
    wire        wr_ok     = done & pwrite & hit_any & pstrb[0];
    wire        rd_clear  = capture & ~pwrite & hit_cause;
    wire        pin_wake  = stop_recovery & wake_from_pin;
    wire        wd_run    = watchdog_timeout & ~in_stop_mode;

    // Wake flag raised by any stop recovery; a watchdog wake also
    // raises the watchdog flag, so both read one together.
    always_comb
    begin
        cause_set = '0;
        cause_set[reset_cause_pkg::WAKE_BIT] = stop_recovery;
        cause_set[reset_cause_pkg::WD_BIT]   = watchdog_timeout;
        cause_set[reset_cause_pkg::PIN_BIT]  = pin_reset_seen;
    end

    always_comb
    begin
        cause_clr = '0;
        cause_clr[reset_cause_pkg::WAKE_BIT] = rd_clear | wd_run;
        cause_clr[reset_cause_pkg::WD_BIT]   = rd_clear | pin_wake;
        cause_clr[reset_cause_pkg::PIN_BIT]  = rd_clear | pin_wake;
    end

    // Power-on reset clears every cause flag; sets win over clears.
    sticky_flag #(
        .W         (reset_cause_pkg::REG_W),
        .RESET_VAL (reset_cause_pkg::CAUSE_RESET)
    ) u_cause (
        .clk   (pclk),
        .rst_n (presetn),
        .set   (cause_set & reset_cause_pkg::USED_BITS),
        .clr   (cause_clr),
        .q     (cause_q)
    );

    assign wake_flag               = cause_q[reset_cause_pkg::WAKE_BIT];
    assign watchdog_timeout_flag   = cause_q[reset_cause_pkg::WD_BIT];
    assign external_pin_reset_flag = cause_q[reset_cause_pkg::PIN_BIT];

    // Interrupt status: same layout, cleared by writing a one.
    assign irq_clr = (wr_ok & hit_irq) ? pwdata[7:0] : 8'h00;

    sticky_flag #(
        .W         (reset_cause_pkg::REG_W),
        .RESET_VAL (reset_cause_pkg::IRQ_RESET)
    ) u_irq (
        .clk   (pclk),
        .rst_n (presetn),
        .set   (cause_set & reset_cause_pkg::USED_BITS),
        .clr   (irq_clr),
        .q     (irq_q)
    );

    assign next_irq = |(irq_q & mask);

    // Read data mux; unused positions are zero.
    assign rd_data = hit_cause ? {24'h000000, cause_q}
                   : hit_irq   ? {24'h000000, irq_q}
                   : hit_mask  ? {24'h000000, mask}
                   : 32'h00000000;

    // One wait state: data is captured, then pready answers.
    always_comb
    begin
        next_state = state;
        unique case (state)
            reset_cause_pkg::BUS_IDLE:
                if (access)
                    next_state = reset_cause_pkg::BUS_WAIT;
            reset_cause_pkg::BUS_WAIT:
                next_state = reset_cause_pkg::BUS_DONE;
            reset_cause_pkg::BUS_DONE:
                next_state = reset_cause_pkg::BUS_IDLE;
            default:
                next_state = reset_cause_pkg::BUS_IDLE;
        endcase
    end

    assign next_pready  = state == reset_cause_pkg::BUS_IDLE && access;
    assign next_prdata  = capture ? (pwrite ? 32'h00000000 : rd_data)
                                  : prdata;
    assign next_pslverr = capture & ~hit_any;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state   <= reset_cause_pkg::BUS_IDLE;
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            pready  <= next_pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask <= reset_cause_pkg::MASK_RESET;
            irq  <= 1'b0;
        end
        else
        begin
            if (wr_ok && hit_mask)
                mask <= pwdata[7:0] & reset_cause_pkg::USED_BITS;
            irq <= next_irq;
        end
    end

    // Checks.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable;
    endsequence

    sequence read_cause_s;
        capture && !pwrite && hit_cause;
    endsequence

    sequence pin_wake_s;
        stop_recovery && wake_from_pin && !watchdog_timeout;
    endsequence

    wake_set_a: assert property (
        stop_recovery |=> wake_flag)
        else $error("Stop recovery did not set the wake flag.");

    watchdog_wake_a: assert property (
        stop_recovery && watchdog_timeout
        |=> wake_flag && watchdog_timeout_flag)
        else $error("Watchdog wake did not show both flags.");

    wake_timeout_clr_a: assert property (
        wd_run && !stop_recovery |=> !wake_flag)
        else $error("Watchdog time-out outside stop kept the wake flag.");

    read_clear_a: assert property (
        read_cause_s ##0 !stop_recovery && !watchdog_timeout
        && !pin_reset_seen |=> cause_q == 8'h00)
        else $error("Status read left a cause flag set.");

    watchdog_set_a: assert property (
        watchdog_timeout |=> watchdog_timeout_flag)
        else $error("Watchdog time-out did not set its flag.");

    pin_wake_clr_a: assert property (
        pin_wake_s ##0 !pin_reset_seen
        |=> !watchdog_timeout_flag && !external_pin_reset_flag)
        else $error("Pin wake did not clear watchdog and external flags.");

    pin_set_a: assert property (
        pin_reset_seen |=> external_pin_reset_flag)
        else $error("External reset did not set its flag.");

    reserved_zero_a: assert property (
        read_cause_s |=> prdata[31:3] == 29'h0)
        else $error("Unused status bits read nonzero.");

    set_wins_a: assert property (
        read_cause_s ##0 stop_recovery |=> wake_flag)
        else $error("Clearing read beat a wake event.");

    bus_answer_a: assert property (
        setup_s ##1 access |=> pready ##1 !pready)
        else $error("Access did not answer after one wait state.");

    irq_level_a: assert property (
        (|(irq_q & mask)) |=> irq)
        else $error("Unmasked status did not raise the interrupt.");

    wake_hold_a: assert property (
        wake_flag && !rd_clear && !wd_run |=> wake_flag)
        else $error("Wake flag dropped with no clear.");

    watchdog_hold_a: assert property (
        watchdog_timeout_flag && !rd_clear && !pin_wake
        |=> watchdog_timeout_flag)
        else $error("Watchdog flag dropped with no clear.");

    pin_hold_a: assert property (
        external_pin_reset_flag && !rd_clear && !pin_wake
        |=> external_pin_reset_flag)
        else $error("External flag dropped with no clear.");

    wake_quiet_a: assert property (
        !wake_flag && !stop_recovery |=> !wake_flag)
        else $error("Wake flag rose with no stop recovery.");

    watchdog_quiet_a: assert property (
        !watchdog_timeout_flag && !watchdog_timeout
        |=> !watchdog_timeout_flag)
        else $error("Watchdog flag rose with no time-out.");

    pin_quiet_a: assert property (
        !external_pin_reset_flag && !pin_reset_seen
        |=> !external_pin_reset_flag)
        else $error("External flag rose with no pin reset.");

    wake_read_clr_a: assert property (
        read_cause_s ##0 !stop_recovery |=> !wake_flag)
        else $error("Status read left the wake flag set.");

    watchdog_read_clr_a: assert property (
        read_cause_s ##0 !watchdog_timeout |=> !watchdog_timeout_flag)
        else $error("Status read left the watchdog flag set.");

    pin_read_clr_a: assert property (
        read_cause_s ##0 !pin_reset_seen |=> !external_pin_reset_flag)
        else $error("Status read left the external flag set.");

    stop_keeps_wake_a: assert property (
        wake_flag && watchdog_timeout && in_stop_mode && !rd_clear
        |=> wake_flag)
        else $error("Watchdog time-out in stop cleared the wake flag.");

    read_data_a: assert property (
        read_cause_s |=> prdata[7:0] == $past(cause_q))
        else $error("Status read did not return the cause flags.");

    cause_write_a: assert property (
        done && pwrite && hit_cause && cause_set == 8'h00
        && cause_clr == 8'h00 |=> $stable(cause_q))
        else $error("Write to the status register changed a flag.");

    unused_zero_a: assert property (
        cause_q[7:3] == 5'h00 && irq_q[7:3] == 5'h00)
        else $error("Unused flag bit is set.");

    mask_write_a: assert property (
        wr_ok && hit_mask
        |=> mask == ($past(pwdata[7:0]) & reset_cause_pkg::USED_BITS))
        else $error("Mask write did not store the written bits.");

    mask_keep_a: assert property (
        !(wr_ok && hit_mask) |=> $stable(mask))
        else $error("Mask changed with no mask write.");

    strobe_off_a: assert property (
        done && pwrite && !pstrb[0] |=> $stable(mask))
        else $error("Write without byte strobe changed the mask.");

    irq_clear_a: assert property (
        wr_ok && hit_irq && cause_set == 8'h00
        |=> (irq_q & $past(pwdata[7:0])) == 8'h00)
        else $error("Writing a one did not clear interrupt status.");

    irq_fall_a: assert property (
        !(|(irq_q & mask)) |=> !irq)
        else $error("Interrupt stayed high with nothing unmasked.");

    err_unmapped_a: assert property (
        capture && !hit_any |=> pslverr && pready)
        else $error("Unmapped access did not signal an error.");

    err_mapped_a: assert property (
        capture && hit_any |=> !pslverr)
        else $error("Mapped access signalled an error.");

    err_pulse_a: assert property (
        pslverr |-> pready)
        else $error("Error response without ready.");

    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("Ready stood for more than one cycle.");

    write_zero_a: assert property (
        capture && pwrite |=> prdata == 32'h00000000)
        else $error("Write left read data on the bus.");

endmodule // reset_source_flags

// File: sticky_flag.sv
// Purpose: A row of sticky flags that a set pulse raises and a clear drops.
// Assumes: Set and clear are synchronous to clk.
// Notes:   A set in the same cycle as a clear wins, so no event is lost.
`timescale 1ns/10ps
module sticky_flag #(
    parameter int             W         = 8,
    parameter logic [W-1:0]   RESET_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] q
);

    logic [W-1:0] next_q;

    assign next_q = set | (q & ~clr);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= RESET_VAL;
        else
            q <= next_q;
    end

endmodule // sticky_flag

// File: tb.sv
// Purpose: Self-checking bench for the reset-cause flag block.
// Assumes: One wait state per APB access, flags one cycle after an event.
// Notes:   Event bits are {stop_recovery, watchdog_timeout, pin_reset_seen}.
`timescale 1ns/10ps
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, flags;
    logic [3:0]  pstrb;
    logic        stop_recovery, wake_from_pin, in_stop_mode;
    logic        watchdog_timeout, pin_reset_seen, err;
    logic        irq, wake_flag, watchdog_timeout_flag;
    logic        external_pin_reset_flag;
    int          miscompares, n_compared;
    localparam logic [11:0] CS = reset_cause_pkg::CAUSE_OFFSET;
    localparam logic [11:0] IS = reset_cause_pkg::IRQ_OFFSET;
    localparam logic [11:0] MS = reset_cause_pkg::MASK_OFFSET;

    assign flags = {29'h0, wake_flag, watchdog_timeout_flag,
                    external_pin_reset_flag};

    reset_source_flags uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stop_recovery(stop_recovery),
        .wake_from_pin(wake_from_pin), .in_stop_mode(in_stop_mode),
        .watchdog_timeout(watchdog_timeout), .pin_reset_seen(pin_reset_seen),
        .irq(irq), .wake_flag(wake_flag),
        .watchdog_timeout_flag(watchdog_timeout_flag),
        .external_pin_reset_flag(external_pin_reset_flag));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task print_verdict();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; ev pulses events during the first access cycle.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             input logic [2:0] ev);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        {stop_recovery, watchdog_timeout, pin_reset_seen} <= ev;
        n = 0;
        do
        begin
            @(posedge pclk);
            {stop_recovery, watchdog_timeout, pin_reset_seen} <= 3'h0;
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            miscompares++;
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 3'h0);
        chk(rd, exp);
    endtask

    task pulse(input logic [2:0] ev);
        @(posedge pclk);
        {stop_recovery, watchdog_timeout, pin_reset_seen} <= ev;
        @(posedge pclk);
        {stop_recovery, watchdog_timeout, pin_reset_seen} <= 3'h0;
        repeat (2) @(posedge pclk);
    endtask

    initial
    begin
        #200us;
        miscompares++;
        print_verdict();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {stop_recovery, wake_from_pin, in_stop_mode} = 3'h0;
        {watchdog_timeout, pin_reset_seen} = 2'h0;
        pstrb = 4'hf;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk(flags, 32'h0);
        rdchk(CS, 32'h0);
        rdchk(IS, 32'h0);
        rdchk(MS, 32'h0);
        $display("test reset done");
        pulse(3'h1);
        chk(flags, 32'h1);
        rdchk(CS, 32'h1);
        chk(flags, 32'h0);
        rdchk(CS, 32'h0);
        $display("test external done");
        in_stop_mode <= 1'b1;
        pulse(3'h4);
        pulse(3'h2);
        chk(flags, 32'h6);
        in_stop_mode <= 1'b0;
        rdchk(CS, 32'h6);
        chk(flags, 32'h0);
        pulse(3'h4);
        chk(flags, 32'h4);
        pulse(3'h2);
        chk(flags, 32'h2);
        $display("test watchdog done");
        pulse(3'h1);
        wake_from_pin <= 1'b1;
        pulse(3'h4);
        chk(flags, 32'h4);
        wake_from_pin <= 1'b0;
        rdchk(CS, 32'h4);
        $display("test pin wake done");
        pulse(3'h3);
        apb(1'b1, CS, 32'hffffffff, 3'h0);
        chk(flags, 32'h3);
        rdchk(CS, 32'h3);
        pulse(3'h1);
        apb(1'b0, CS, 32'h0, 3'h7);
        chk(rd, 32'h1);
        chk(flags, 32'h7);
        rdchk(CS, 32'h7);
        $display("test collide done");
        apb(1'b1, IS, 32'h7, 3'h0);
        rdchk(IS, 32'h0);
        apb(1'b1, MS, 32'hff, 3'h0);
        rdchk(MS, 32'h7);
        pulse(3'h2);
        chk({31'h0, irq}, 32'h1);
        rdchk(CS, 32'h2);
        apb(1'b1, IS, 32'h2, 3'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        pstrb <= 4'h0;
        apb(1'b1, MS, 32'h0, 3'h0);
        pstrb <= 4'hf;
        rdchk(MS, 32'h7);
        apb(1'b1, MS, 32'h0, 3'h0);
        pulse(3'h1);
        chk({31'h0, irq}, 32'h0);
        rdchk(IS, 32'h1);
        apb(1'b0, 12'h00c, 32'h0, 3'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test interrupt done");
        pulse(3'h7);
        chk(flags, 32'h7);
        presetn <= 1'b0;
        @(posedge pclk);
        chk(flags, 32'h0);
        chk({31'h0, irq}, 32'h0);
        presetn <= 1'b1;
        rdchk(IS, 32'h0);
        rdchk(CS, 32'h0);
        $display("test reset again done");
        print_verdict();
    end
endmodule // tb
